// ===== cef_can_node.sv
`timescale 1ns/1ps
module cef_can_node
    import cef_pkg::*;
(
    input  wire logic aclk,
    output logic      rx_bit,
    output logic      rx_sample
);
    // Idle is recessive, the level the bus pull-up gives.
    initial begin
        rx_bit = 1'b1;
        rx_sample = 1'b0;
    end
    task automatic put(input logic v);
        @(posedge aclk);
        rx_bit <= v;
        repeat (2) @(posedge aclk);
        rx_sample <= 1'b1;
        @(posedge aclk);
        rx_sample <= 1'b0;
    endtask
    // Kind 0 is a clean frame; kinds 1 to 5 each break one field.
    task automatic send(input int kind);
        logic [41:0] body;
        logic [14:0] crc;
        logic        s[$];
        int          run;
        body = {1'b0, 11'h5a3, 3'b000, 4'h1, 8'h3c, 15'h0000};
        crc = 15'h0000;
        run = 0;
        for (int i = 41; i >= 15; i--) begin
            crc = {crc[13:0], 1'b0} ^ ((body[i] ^ crc[14]) ? CEF_CRC_POLY : 15'h0000);
        end
        body[14:0] = crc ^ 15'(kind == 1);
        for (int i = 41; i >= 0; i--) begin
            run = (s.size() > 0 && body[i] == s[$]) ? run + 1 : 1;
            s.push_back(body[i]);
            if (run == 5) begin
                s.push_back(!body[i]);
                run = 1;
            end
        end
        s.push_back(kind != 2);
        s.push_back(kind == 3);
        s.push_back(1'b1);
        for (int i = 0; i < 7; i++) s.push_back(kind != 4 || i != 3);
        if (kind == 5) s = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        foreach (s[i]) put(s[i]);
        repeat (11) put(1'b1);
    endtask
endmodule

// ===== cef_flag.sv
`timescale 1ns/1ps
module cef_flag
    import cef_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    typedef struct packed {
        logic f;
    } cef_flag_s;
    cef_flag_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (clr_i) begin
            st_d.f = 1'b0;
        end
        if (set_i) begin
            st_d.f = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.f;
endmodule

// ===== cef_pkg.sv
// What this block does
// - Set the buffer overrun flag when the receive buffer becomes full; 1 means active.
// - Overrun flag holds until software clears it after handling the overrun.
// - Receiver computes CRC over destuffed bits from start of frame through data.
// - Set CRC error flag when computed CRC differs from received CRC field.
// - Set form error flag on bad CRC delimiter, ack delimiter or end of frame.
// - Stuff, CRC, form and ack error flags can request interrupt; sticky until cleared.
// - After reset the overrun flag and all error flags read zero.
package cef_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0]  CEF_FLAGS_OFFSET = 8'h00;
    localparam logic [7:0]  CEF_IRQEN_OFFSET = 8'h04;
    localparam logic [7:0]  CEF_STAT_OFFSET  = 8'h08;
    localparam int          CEF_ACK_BIT      = 0;
    localparam int          CEF_FORM_BIT     = 1;
    localparam int          CEF_CRC_BIT      = 2;
    localparam int          CEF_STUFF_BIT    = 3;
    localparam int          CEF_OVR_BIT      = 4;
    localparam logic [4:0]  CEF_FLAGS_RESET  = 5'h00;
    localparam logic [4:0]  CEF_IRQEN_RESET  = 5'h00;
    localparam logic [1:0]  CEF_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  CEF_RESP_SLVERR  = 2'h2;

    // ==========================================================
    // Frame constants
    localparam logic [2:0]  CEF_STUFF_LIMIT  = 3'h5;
    localparam logic [14:0] CEF_CRC_POLY     = 15'h4599;
    localparam logic [2:0]  CEF_EOF_BITS     = 3'h7;
    localparam logic [4:0]  CEF_ARB_BITS     = 5'h13;

    typedef enum logic [3:0] {
        CEF_IDLE  = 4'h0,
        CEF_HEAD  = 4'h1,
        CEF_DLC   = 4'h2,
        CEF_DATA  = 4'h3,
        CEF_CRC   = 4'h4,
        CEF_CDEL  = 4'h5,
        CEF_ACK   = 4'h6,
        CEF_ADEL  = 4'h7,
        CEF_EOF   = 4'h8
    } cef_state_e;

endpackage

// ===== cef_properties.sv
`timescale 1ns/1ps
// ====================
// Port checks
module cef_properties
    import cef_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        rx_buf_full,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [4:0]  err_flags,
    input wire logic        err_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_zero_a: assert property (
        $past(!aresetn && ce) |-> !err_irq && err_flags == 5'h00) else $error("bad reset");
    overrun_set_a: assert property (
        ce && $rose(rx_buf_full) |-> ##[1:2] err_flags[CEF_OVR_BIT]) else $error("no overrun");
    flag_sticky_a: assert property (
        (|($past(err_flags) & ~err_flags)) |-> $past(s_axi_wvalid && s_axi_wready)
        || $past(s_axi_wvalid && s_axi_wready, 2)) else $error("flag fell alone");
    irq_cause_a: assert property (err_flags == 5'h00 |-> !err_irq)
        else $error("irq without flag");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    wready_busy_a: assert property (s_axi_bvalid |-> !s_axi_wready)
        else $error("wready while busy");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    unmapped_read_a: assert property (ce && s_axi_arvalid && s_axi_arready
        && (s_axi_araddr & 8'hfc) > CEF_STAT_OFFSET |=> s_axi_rvalid && s_axi_rdata == 32'h0
        && s_axi_rresp == CEF_RESP_SLVERR) else $error("unmapped read");
    cover property (err_flags[CEF_STUFF_BIT] && err_irq);
    cover property (err_flags[CEF_CRC_BIT]);
    cover property (s_axi_rvalid && s_axi_rresp == CEF_RESP_SLVERR);
endmodule
bind cef_top cef_properties i_props (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .rx_buf_full(rx_buf_full), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .err_flags(err_flags), .err_irq(err_irq));

// ===== cef_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
module cef_tb_top
    import cef_pkg::*;
;
    logic        aclk, aresetn, buf_full, rx_bit, rx_sample, irq, ce;
    logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd, got;
    logic [1:0]  bresp, rresp, rsp;
    logic [4:0]  flags;
    logic [4:0]  exp_tab [6];
    int          num_errors, samples_checked;
    cef_top i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .rx_bit(rx_bit),
        .rx_sample(rx_sample), .rx_buf_full(buf_full), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .err_flags(flags), .err_irq(irq));
    cef_can_node i_node (.aclk(aclk), .rx_bit(rx_bit), .rx_sample(rx_sample));
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awa <= a;
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        br  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while ((awv && awr !== 1'b1) || (wv && wr !== 1'b1));
        do @(posedge aclk); while (bv !== 1'b1);
        rsp = bresp;
        br <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr  <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        got = rd;
        rsp = rresp;
        rr  <= 1'b0;
    endtask
    task automatic expect_flags(input logic [4:0] e);
        rd_reg(CEF_FLAGS_OFFSET);
        `CHK(got, 32'(e))
        `CHK(flags, e)
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        #800000;
        num_errors++;
        print_verdict();
    end
    initial begin
        {aresetn, buf_full, awv, wv, br, arv, rr} = 7'h00;
        {awa, ara, wd} = '0;
        ce = 1'b1;
        exp_tab = '{5'h00, 5'h1 << CEF_CRC_BIT, 5'h1 << CEF_FORM_BIT, 5'h1 << CEF_ACK_BIT,
                    5'h1 << CEF_FORM_BIT, 5'h1 << CEF_STUFF_BIT};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        expect_flags(5'h00);
        rd_reg(CEF_IRQEN_OFFSET);
        `CHK(got, 32'h0)
        $display("test reset finished");
        buf_full <= 1'b1;
        repeat (3) @(posedge aclk);
        buf_full <= 1'b0;
        expect_flags(5'h1 << CEF_OVR_BIT);
        wr_reg(CEF_FLAGS_OFFSET, 32'h0f);
        expect_flags(5'h1 << CEF_OVR_BIT);
        buf_full <= 1'b1;
        expect_flags(5'h1 << CEF_OVR_BIT);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        buf_full <= 1'b0;
        expect_flags(5'h00);
        ce <= 1'b0;
        buf_full <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK(flags, 5'h00)
        ce <= 1'b1;
        expect_flags(5'h1 << CEF_OVR_BIT);
        wr_reg(CEF_FLAGS_OFFSET, 32'h10);
        expect_flags(5'h00);
        buf_full <= 1'b0;
        $display("test overrun finished");
        wr_reg(CEF_IRQEN_OFFSET, 32'h1f);
        for (int k = 0; k < 6; k++) begin
            i_node.send(k);
            if (k == 5) i_node.send(k);
            expect_flags(exp_tab[k]);
            `CHK(irq, exp_tab[k] != 5'h00)
            if (k == 5) wr_reg(CEF_IRQEN_OFFSET, 32'h0);
            `CHK(irq, exp_tab[k] != 5'h00 && k != 5)
            wr_reg(CEF_FLAGS_OFFSET, 32'h1f);
            expect_flags(5'h00);
            $display("test frame %0d finished", k);
        end
        rd_reg(8'h40);
        `CHK(rsp, CEF_RESP_SLVERR)
        `CHK(got, 32'h0)
        wr_reg(8'h40, 32'h1f);
        `CHK(rsp, CEF_RESP_SLVERR)
        rd_reg(CEF_STAT_OFFSET);
        `CHK(rsp, CEF_RESP_OKAY)
        `CHK(got, 32'(CEF_IDLE))
        $display("test unmapped finished");
        print_verdict();
    end
endmodule

// ===== cef_top.sv
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cef_top
    import cef_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic        rx_bit,
    input  wire logic        rx_sample,
    input  wire logic        rx_buf_full,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [4:0]       err_flags,
    output logic             err_irq
);
    // ==========================================================
    // State
    typedef struct packed {
        cef_state_e  fsm;
        logic [5:0]  cnt;
        logic [3:0]  dlc;
        logic        ide;
        logic [14:0] crc;
        logic [14:0] crc_rx;
        logic        last;
        logic [2:0]  run;
        logic        stuff_nxt;
        logic        full_q;
        logic [4:0]  irqen;
        logic        aw_ok;
        logic [7:0]  awa;
        logic        w_ok;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        bv;
        logic [1:0]  br;
        logic        rv;
        logic [31:0] rd;
        logic [1:0]  rr;
    } cef_top_s;
    cef_top_s st_q, st_d;

    logic [4:0] set_v;
    logic [4:0] clr_v;
    logic [4:0] flags;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_flag
            cef_flag u_flag (
                .aclk    (aclk),
                .aresetn (aresetn),
                .ce      (ce),
                .set_i   (set_v[gi]),
                .clr_i   (clr_v[gi]),
                .flag_o  (flags[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Frame checker and bus slave
    logic       crc_fb;
    logic       wr_go;
    logic       stuffed;
    logic       bitv;
    logic       data_end;

    always_comb begin
        st_d     = st_q;
        set_v    = '0;
        clr_v    = '0;
        bitv     = rx_sample & ~st_q.stuff_nxt;
        stuffed  = 1'b0;
        data_end = 1'b0;
        crc_fb   = rx_bit ^ st_q.crc[14];

        st_d.full_q = rx_buf_full;
        set_v[CEF_OVR_BIT] = rx_buf_full & ~st_q.full_q;

        // Stuff bits are dropped here, so every later field sees destuffed data.
        if (rx_sample && st_q.stuff_nxt) begin
            st_d.stuff_nxt = 1'b0;
            if (rx_bit == st_q.last) begin
                set_v[CEF_STUFF_BIT] = 1'b1;
                st_d.fsm = CEF_IDLE;
            end
            st_d.last = rx_bit;
            st_d.run  = 3'h1;
        end

        if (bitv) begin
            if (st_q.fsm inside {CEF_HEAD, CEF_DLC, CEF_DATA, CEF_CRC}) begin
                stuffed = 1'b1;
                if (rx_bit == st_q.last) begin
                    st_d.run = st_q.run + 3'h1;
                end else begin
                    st_d.run = 3'h1;
                end
                st_d.last = rx_bit;
                st_d.stuff_nxt = (rx_bit == st_q.last) ? (st_q.run + 3'h1 == CEF_STUFF_LIMIT)
                                                       : 1'b0;
            end
            if (st_q.fsm inside {CEF_HEAD, CEF_DLC, CEF_DATA}) begin
                st_d.crc = {st_q.crc[13:0], 1'b0} ^ (crc_fb ? CEF_CRC_POLY : 15'h0000);
            end
            st_d.cnt = st_q.cnt + 6'h01;
            unique case (st_q.fsm)
                CEF_IDLE: begin
                    if (!rx_bit) begin
                        st_d.fsm  = CEF_HEAD;
                        st_d.cnt  = '0;
                        st_d.last = 1'b0;
                        st_d.run  = 3'h1;
                        st_d.stuff_nxt = 1'b0;
                        st_d.ide  = 1'b0;
                        // A dominant start bit into a cleared register leaves it clear,
                        // so no remainder of the previous frame can leak in.
                        st_d.crc  = 15'h0000;
                    end
                end
                CEF_HEAD: begin
                    // Identifier, RTR/SRR, IDE and r0 are passed over; IDE picks length.
                    if (st_q.cnt == 6'h0c) begin
                        st_d.ide = rx_bit;
                    end
                    if ((!st_q.ide && st_q.cnt == 6'h0d) ||
                        (st_q.ide && st_q.cnt == 6'h0d + {1'b0, CEF_ARB_BITS} + 6'h01)) begin
                        st_d.fsm = CEF_DLC;
                        st_d.cnt = '0;
                    end
                end
                CEF_DLC: begin
                    st_d.dlc = {st_q.dlc[2:0], rx_bit};
                    if (st_q.cnt == 6'h03) begin
                        st_d.cnt = '0;
                        if ({st_q.dlc[2:0], rx_bit} == 4'h0) begin
                            st_d.fsm = CEF_CRC;
                        end else begin
                            st_d.fsm = CEF_DATA;
                        end
                    end
                end
                CEF_DATA: begin
                    data_end = (st_q.dlc[3] ? 6'h3f : {st_q.dlc[2:0], 3'h0} - 6'h01)
                               == st_q.cnt;
                    if (data_end) begin
                        st_d.fsm = CEF_CRC;
                        st_d.cnt = '0;
                    end
                end
                CEF_CRC: begin
                    st_d.crc_rx = {st_q.crc_rx[13:0], rx_bit};
                    if (st_q.cnt == 6'h0e) begin
                        st_d.fsm = CEF_CDEL;
                        set_v[CEF_CRC_BIT] = {st_q.crc_rx[13:0], rx_bit} != st_q.crc;
                    end
                end
                CEF_CDEL: begin
                    set_v[CEF_FORM_BIT] = ~rx_bit;
                    st_d.fsm = CEF_ACK;
                end
                CEF_ACK: begin
                    set_v[CEF_ACK_BIT] = rx_bit;
                    st_d.fsm = CEF_ADEL;
                end
                CEF_ADEL: begin
                    set_v[CEF_FORM_BIT] = ~rx_bit;
                    st_d.fsm = CEF_EOF;
                    st_d.cnt = '0;
                end
                CEF_EOF: begin
                    set_v[CEF_FORM_BIT] = ~rx_bit;
                    if (st_q.cnt == {3'h0, CEF_EOF_BITS} - 6'h01) begin
                        st_d.fsm = CEF_IDLE;
                    end
                end
                default: st_d.fsm = CEF_IDLE;
            endcase
            if (st_q.fsm == CEF_DATA && st_q.dlc[3] && st_q.cnt == 6'h3f) begin
                st_d.fsm = CEF_CRC;
                st_d.cnt = '0;
            end
        end

        // AXI4-Lite write: address and data taken in either order.
        if (s_axi_awvalid && !st_q.aw_ok && !st_q.bv) begin
            st_d.aw_ok = 1'b1;
            st_d.awa   = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_ok && !st_q.bv) begin
            st_d.w_ok = 1'b1;
            st_d.wd   = s_axi_wdata;
            st_d.ws   = s_axi_wstrb;
        end
        wr_go = st_q.aw_ok && st_q.w_ok && !st_q.bv;
        if (wr_go) begin
            st_d.aw_ok = 1'b0;
            st_d.w_ok  = 1'b0;
            st_d.bv    = 1'b1;
            st_d.br    = CEF_RESP_OKAY;
            unique case (st_q.awa & 8'hfc)
                CEF_FLAGS_OFFSET: if (st_q.ws[0]) clr_v = st_q.wd[4:0];
                CEF_IRQEN_OFFSET: if (st_q.ws[0]) st_d.irqen = st_q.wd[4:0];
                CEF_STAT_OFFSET:  st_d.br = CEF_RESP_OKAY;
                default:          st_d.br = CEF_RESP_SLVERR;
            endcase
        end
        if (st_q.bv && s_axi_bready) begin
            st_d.bv = 1'b0;
        end
        if (s_axi_arvalid && !st_q.rv) begin
            st_d.rv = 1'b1;
            st_d.rr = CEF_RESP_OKAY;
            unique case (s_axi_araddr & 8'hfc)
                CEF_FLAGS_OFFSET: st_d.rd = {27'h0, flags};
                CEF_IRQEN_OFFSET: st_d.rd = {27'h0, st_q.irqen};
                CEF_STAT_OFFSET:  st_d.rd = {28'h0, st_q.fsm};
                default: begin
                    st_d.rd = 32'h0;
                    st_d.rr = CEF_RESP_SLVERR;
                end
            endcase
        end else if (st_q.rv && s_axi_rready) begin
            st_d.rv = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q       <= '0;
            st_q.fsm   <= CEF_IDLE;
            st_q.last  <= 1'b1;
            st_q.irqen <= CEF_IRQEN_RESET;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    assign s_axi_awready = !st_q.aw_ok && !st_q.bv;
    assign s_axi_wready  = !st_q.w_ok && !st_q.bv;
    assign s_axi_bvalid  = st_q.bv;
    assign s_axi_bresp   = st_q.br;
    assign s_axi_arready = !st_q.rv;
    assign s_axi_rvalid  = st_q.rv;
    assign s_axi_rdata   = st_q.rd;
    assign s_axi_rresp   = st_q.rr;
    assign err_flags     = flags;
    assign err_irq       = |(flags & st_q.irqen);
endmodule
